//--- src/ltc_pkg.sv
// Register map, field layout and reset values of the display timing block.
package ltc_pkg;
  localparam int LTC_ADDR_W = 12;
  localparam int LTC_NUM_LAYERS = 2;
  localparam logic [11:0] LTC_OFS_SYNC = 12'h008;
  localparam logic [11:0] LTC_OFS_PORCH = 12'h00C;
  localparam logic [11:0] LTC_OFS_ACTIVE = 12'h010;
  localparam logic [11:0] LTC_OFS_TOTAL = 12'h014;
  localparam logic [11:0] LTC_OFS_GLOBAL = 12'h018;
  localparam logic [11:0] LTC_OFS_RELOAD = 12'h024;
  localparam logic [11:0] LTC_OFS_IRQ_EN = 12'h034;
  localparam logic [11:0] LTC_OFS_IRQ_STAT = 12'h038;
  localparam logic [11:0] LTC_OFS_IRQ_CLR = 12'h03C;
  localparam logic [11:0] LTC_OFS_LINE_POS = 12'h040;
  localparam logic [11:0] LTC_OFS_SCAN_POS = 12'h044;
  localparam logic [11:0] LTC_OFS_LAYER_BASE = 12'h084;
  localparam logic [11:0] LTC_OFS_LAYER_STRIDE = 12'h080;
  // Horizontal fields sit at 27:16, vertical fields at 10:0.
  localparam int LTC_H_LSB = 16;
  localparam int LTC_H_W = 12;
  localparam int LTC_V_LSB = 0;
  localparam int LTC_V_W = 11;
  localparam int LTC_GCR_HSYNC_POLARITY_BIT = 31;
  localparam int LTC_GCR_VSYNC_POLARITY_BIT = 30;
  localparam int LTC_GCR_DATA_ENABLE_POLARITY_BIT = 29;
  localparam int LTC_GCR_PCPOL_BIT = 28;
  localparam int LTC_GCR_DITHER_BIT = 16;
  localparam int LTC_GCR_EN_BIT = 0;
  localparam logic [2:0] LTC_DITHER_W = 3'h2;
  localparam int LTC_RELOAD_IMM_BIT = 0;
  localparam int LTC_RELOAD_BLANK_BIT = 1;
  // Event bit positions shared by enable, status and clear registers.
  localparam int LTC_EV_LINE = 0;
  localparam int LTC_EV_UNDERRUN = 1;
  localparam int LTC_EV_BUSERR = 2;
  localparam int LTC_EV_RELOAD = 3;
  localparam logic [3:0] LTC_EV_GROUP_A = 4'h9;
  localparam logic [3:0] LTC_EV_GROUP_B = 4'h6;
  localparam logic [31:0] LTC_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] LTC_RST_GLOBAL = 32'h0000_2220;
endpackage : ltc_pkg

//--- src/ltc_tim_if.sv
// Signals between the register side and the scan timing generator.
`timescale 1ns/1ns
`default_nettype none
interface ltc_tim_if;
  logic tick;
  logic enable;
  logic [11:0] hsync_width_field, accum_horiz_back_porch, accum_active_width, totw;
  logic [10:0] vsync_height_field, accum_vert_back_porch, accum_active_height, toth;
  logic [11:0] pixCnt;
  logic [10:0] lineCnt;
  logic lineStart;
  logic hsAct, vsAct, deAct;
  modport gen (
    input tick, enable, hsync_width_field, accum_horiz_back_porch, accum_active_width, totw, vsync_height_field, accum_vert_back_porch, accum_active_height, toth,
    output pixCnt, lineCnt, lineStart, hsAct, vsAct, deAct
  );
  modport ctl (
    output tick, enable, hsync_width_field, accum_horiz_back_porch, accum_active_width, totw, vsync_height_field, accum_vert_back_porch, accum_active_height, toth,
    input pixCnt, lineCnt, lineStart, hsAct, vsAct, deAct
  );
endinterface : ltc_tim_if
`default_nettype wire

//--- src/ltc_timing_gen.sv
// Pixel and line counters with sync and data enable decoding.
`timescale 1ns/1ns
`default_nettype none
module ltc_timing_gen
  import ltc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Timing link to the register side.
  ltc_tim_if.gen tim
);
  typedef struct packed {
    logic [11:0] pix;
    logic [10:0] line;
    logic lineStart;
  } ltc_gen_state_t;

  ltc_gen_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.lineStart = 1'b0;
    if (!tim.enable) begin
      nxt_st.pix = 12'h000;
      nxt_st.line = 11'h000;
    end else if (tim.tick) begin
      if (st_ff.pix >= tim.totw) begin
        nxt_st.pix = 12'h000;
        nxt_st.lineStart = 1'b1;
        if (st_ff.line >= tim.toth) begin
          nxt_st.line = 11'h000;
        end else begin
          nxt_st.line = st_ff.line + 11'h001;
        end
      end else begin
        nxt_st.pix = st_ff.pix + 12'h001;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tim.pixCnt = st_ff.pix;
  assign tim.lineCnt = st_ff.line;
  assign tim.lineStart = st_ff.lineStart;
  // Sync pulses span counts 0 to width; back porch then runs to the
  // accumulated porch value, so active pixels begin one count later.
  assign tim.hsAct = tim.enable && (st_ff.pix <= tim.hsync_width_field);
  assign tim.vsAct = tim.enable && (st_ff.line <= tim.vsync_height_field);
  assign tim.deAct = tim.enable && (st_ff.pix > tim.accum_horiz_back_porch) &&
    (st_ff.pix <= tim.accum_active_width) && (st_ff.line > tim.accum_vert_back_porch) &&
    (st_ff.line <= tim.accum_active_height);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_pix_wrap: assert property (
    tim.enable && tim.tick && st_ff.pix >= tim.totw && $stable(tim.enable)
    |=> st_ff.pix == 12'h000 && st_ff.lineStart)
    else $error("Pixel counter did not wrap at total width.");
  a_line_wrap: assert property (
    tim.enable && tim.tick && st_ff.pix >= tim.totw &&
    st_ff.line >= tim.toth |=> st_ff.line == 11'h000)
    else $error("Line counter did not wrap at total height.");
  a_pix_hold: assert property (
    tim.enable && !tim.tick |=> $stable(st_ff.pix) || !tim.enable)
    else $error("Pixel counter moved without a pixel clock edge.");
  c_frame_wrap: cover property (
    tim.enable && tim.tick && st_ff.pix >= tim.totw &&
    st_ff.line >= tim.toth);
endmodule : ltc_timing_gen
`default_nettype wire

//--- src/ltc_top.sv
// Display timing, event flags, interrupt lines and shadowed layer registers.
//
// The APB interface to the registers answers with no wait states.
`timescale 1ns/1ns
`default_nettype none
module ltc_top
  import ltc_pkg::*;
#(
  parameter int NUM_LAYERS = LTC_NUM_LAYERS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LTC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the fetch path.
  input wire logic underrunEvent,
  input wire logic busErrorEvent,
  // Panel pins.
  input wire logic pixClkIn,
  output logic hsyncOut,
  output logic vsyncOut,
  output logic dataEnableOut,
  // Interrupt lines.
  output logic irqScan,
  output logic irqFault,
  // Active settings for the pixel path.
  output logic ditherEnable,
  output logic [NUM_LAYERS*32-1:0] layerActive
);
  typedef struct packed {
    logic [2:0] pcSync;
    logic [11:0] hsync_width_field, accum_horiz_back_porch, accum_active_width, totw;
    logic [10:0] vsync_height_field, accum_vert_back_porch, accum_active_height, toth;
    logic hsync_polarity, vsync_polarity, data_enable_polarity, pcPol;
    logic ditherEn;
    logic ctrlEn;
    logic [10:0] linePos;
    logic [3:0] ier;
    logic [3:0] isr;
    logic immediate_reload_request;
    logic blanking_reload_request;
    logic [NUM_LAYERS-1:0][31:0] shadow;
    logic [NUM_LAYERS-1:0][31:0] active;
    logic [31:0] rdata;
    logic hsOut, vsOut, deOut;
  } ltc_top_state_t;

  ltc_top_state_t st_ff, nxt_st;
  ltc_tim_if tif ();

  logic [31:0] rdMux;
  logic hit;
  logic wrEn;
  logic blankStart;
  logic lineEvent;
  logic [3:0] evSet;
  logic [3:0] evClr;

  ltc_timing_gen u_gen (
    .core_clk (core_clk),
    .rst (rst),
    .tim (tif)
  );

  // A falling edge is used when the panel wants the inverted pixel clock.
  assign tif.tick = st_ff.pcPol ? (!st_ff.pcSync[1] && st_ff.pcSync[2]) :
    (st_ff.pcSync[1] && !st_ff.pcSync[2]);
  assign tif.enable = st_ff.ctrlEn;
  assign tif.hsync_width_field = st_ff.hsync_width_field;
  assign tif.accum_horiz_back_porch = st_ff.accum_horiz_back_porch;
  assign tif.accum_active_width = st_ff.accum_active_width;
  assign tif.totw = st_ff.totw;
  assign tif.vsync_height_field = st_ff.vsync_height_field;
  assign tif.accum_vert_back_porch = st_ff.accum_vert_back_porch;
  assign tif.accum_active_height = st_ff.accum_active_height;
  assign tif.toth = st_ff.toth;

  assign wrEn = psel && penable && pwrite && hit;
  assign blankStart = tif.lineStart &&
    (tif.lineCnt == st_ff.accum_active_height + 11'h001);
  assign lineEvent = tif.lineStart && (tif.lineCnt == st_ff.linePos);

  always_comb begin
    rdMux = LTC_RST_ZERO;
    hit = 1'b1;
    case (paddr)
      LTC_OFS_SYNC: rdMux = {4'h0, st_ff.hsync_width_field, 5'h00, st_ff.vsync_height_field};
      LTC_OFS_PORCH: rdMux = {4'h0, st_ff.accum_horiz_back_porch, 5'h00, st_ff.accum_vert_back_porch};
      LTC_OFS_ACTIVE: rdMux = {4'h0, st_ff.accum_active_width, 5'h00, st_ff.accum_active_height};
      LTC_OFS_TOTAL: rdMux = {4'h0, st_ff.totw, 5'h00, st_ff.toth};
      LTC_OFS_GLOBAL: rdMux = {st_ff.hsync_polarity, st_ff.vsync_polarity, st_ff.data_enable_polarity,
        st_ff.pcPol, 11'h000, st_ff.ditherEn, 1'b0, LTC_DITHER_W, 1'b0,
        LTC_DITHER_W, 1'b0, LTC_DITHER_W, 3'h0, st_ff.ctrlEn};
      LTC_OFS_RELOAD: rdMux = {30'h0000_0000, st_ff.blanking_reload_request, st_ff.immediate_reload_request};
      LTC_OFS_IRQ_EN: rdMux = {28'h000_0000, st_ff.ier};
      LTC_OFS_IRQ_STAT: rdMux = {28'h000_0000, st_ff.isr};
      LTC_OFS_IRQ_CLR: rdMux = LTC_RST_ZERO;
      LTC_OFS_LINE_POS: rdMux = {21'h00_0000, st_ff.linePos};
      LTC_OFS_SCAN_POS: rdMux = {4'h0, tif.pixCnt, 5'h00, tif.lineCnt};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < NUM_LAYERS; i++) begin
          if (paddr == LTC_OFS_LAYER_BASE +
              LTC_ADDR_W'(i) * LTC_OFS_LAYER_STRIDE) begin
            hit = 1'b1;
            rdMux = st_ff.active[i];
          end
        end
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    evSet = 4'h0;
    evClr = 4'h0;
    // Only the second and third stages feed the edge detector.
    nxt_st.pcSync = {st_ff.pcSync[1:0], pixClkIn};
    nxt_st.hsOut = st_ff.hsync_polarity ? tif.hsAct : !tif.hsAct;
    nxt_st.vsOut = st_ff.vsync_polarity ? tif.vsAct : !tif.vsAct;
    nxt_st.deOut = st_ff.data_enable_polarity ? tif.deAct : !tif.deAct;
    // Read data is caught in the setup phase so it comes from a flop.
    if (psel && !penable && !pwrite) begin
      nxt_st.rdata = rdMux;
    end
    // Immediate reload wins over a blanking reload pending in parallel.
    if (st_ff.immediate_reload_request) begin
      nxt_st.active = st_ff.shadow;
      nxt_st.immediate_reload_request = 1'b0;
    end else if (st_ff.blanking_reload_request && blankStart) begin
      nxt_st.active = st_ff.shadow;
      nxt_st.blanking_reload_request = 1'b0;
      evSet[LTC_EV_RELOAD] = 1'b1;
    end
    evSet[LTC_EV_LINE] = lineEvent;
    evSet[LTC_EV_UNDERRUN] = underrunEvent;
    evSet[LTC_EV_BUSERR] = busErrorEvent;
    if (wrEn) begin
      case (paddr)
        LTC_OFS_SYNC: begin
          nxt_st.hsync_width_field = pwdata[LTC_H_LSB +: LTC_H_W];
          nxt_st.vsync_height_field = pwdata[LTC_V_LSB +: LTC_V_W];
        end
        LTC_OFS_PORCH: begin
          nxt_st.accum_horiz_back_porch = pwdata[LTC_H_LSB +: LTC_H_W];
          nxt_st.accum_vert_back_porch = pwdata[LTC_V_LSB +: LTC_V_W];
        end
        LTC_OFS_ACTIVE: begin
          nxt_st.accum_active_width = pwdata[LTC_H_LSB +: LTC_H_W];
          nxt_st.accum_active_height = pwdata[LTC_V_LSB +: LTC_V_W];
        end
        LTC_OFS_TOTAL: begin
          nxt_st.totw = pwdata[LTC_H_LSB +: LTC_H_W];
          nxt_st.toth = pwdata[LTC_V_LSB +: LTC_V_W];
        end
        LTC_OFS_GLOBAL: begin
          nxt_st.hsync_polarity = pwdata[LTC_GCR_HSYNC_POLARITY_BIT];
          nxt_st.vsync_polarity = pwdata[LTC_GCR_VSYNC_POLARITY_BIT];
          nxt_st.data_enable_polarity = pwdata[LTC_GCR_DATA_ENABLE_POLARITY_BIT];
          nxt_st.pcPol = pwdata[LTC_GCR_PCPOL_BIT];
          nxt_st.ditherEn = pwdata[LTC_GCR_DITHER_BIT];
          nxt_st.ctrlEn = pwdata[LTC_GCR_EN_BIT];
        end
        LTC_OFS_RELOAD: begin
          // A zero write leaves a pending request alone.
          if (pwdata[LTC_RELOAD_IMM_BIT]) begin
            nxt_st.immediate_reload_request = 1'b1;
          end
          if (pwdata[LTC_RELOAD_BLANK_BIT]) begin
            nxt_st.blanking_reload_request = 1'b1;
          end
        end
        LTC_OFS_IRQ_EN: nxt_st.ier = pwdata[3:0];
        LTC_OFS_IRQ_CLR: evClr = pwdata[3:0];
        LTC_OFS_LINE_POS: nxt_st.linePos = pwdata[10:0];
        default: begin
          for (int i = 0; i < NUM_LAYERS; i++) begin
            if (paddr == LTC_OFS_LAYER_BASE +
                LTC_ADDR_W'(i) * LTC_OFS_LAYER_STRIDE) begin
              nxt_st.shadow[i] = pwdata;
            end
          end
        end
      endcase
    end
    // A flag set in the cycle of its clear survives.
    nxt_st.isr = (st_ff.isr & ~evClr) | evSet;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign hsyncOut = st_ff.hsOut;
  assign vsyncOut = st_ff.vsOut;
  assign dataEnableOut = st_ff.deOut;
  assign irqScan = |(st_ff.isr & st_ff.ier & LTC_EV_GROUP_A);
  assign irqFault = |(st_ff.isr & st_ff.ier & LTC_EV_GROUP_B);
  assign ditherEnable = st_ff.ditherEn;
  assign layerActive = st_ff.active;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_line_flag: assert property (
    lineEvent |=> st_ff.isr[LTC_EV_LINE])
    else $error("Line flag missed at programmed line.");
  a_reload_flag: assert property (
    st_ff.blanking_reload_request && blankStart && !st_ff.immediate_reload_request
    |=> st_ff.isr[LTC_EV_RELOAD] && !st_ff.blanking_reload_request &&
    st_ff.active == $past(st_ff.shadow))
    else $error("Blanking reload did not complete.");
  a_underrun_flag: assert property (
    underrunEvent |=> st_ff.isr[LTC_EV_UNDERRUN])
    else $error("Underrun flag missed.");
  a_buserr_flag: assert property (
    busErrorEvent |=> st_ff.isr[LTC_EV_BUSERR])
    else $error("Bus error flag missed.");
  a_irq_mask: assert property (
    st_ff.ier == 4'h0 |-> !irqScan && !irqFault)
    else $error("Masked event reached an interrupt line.");
  a_imm_reload: assert property (
    st_ff.immediate_reload_request |=> !st_ff.immediate_reload_request && st_ff.active == $past(st_ff.shadow))
    else $error("Immediate reload did not copy shadow values.");
  a_shadow_hold: assert property (
    !st_ff.immediate_reload_request && !(st_ff.blanking_reload_request && blankStart) |=> $stable(st_ff.active))
    else $error("Active layer value changed without a reload.");
  a_read_active: assert property (
    psel && !penable && !pwrite && paddr == LTC_OFS_LAYER_BASE
    |=> prdata == $past(st_ff.active[0]))
    else $error("Layer read did not return the active value.");
  a_de_polarity: assert property (
    !st_ff.ctrlEn ##1 !st_ff.ctrlEn |=> dataEnableOut == !$past(st_ff.data_enable_polarity, 1))
    else $error("Idle data enable not at inactive level.");
  c_blank_reload: cover property (st_ff.blanking_reload_request && blankStart);
  c_imm_reload: cover property (st_ff.immediate_reload_request);
  c_scan_irq: cover property (irqScan ##1 !irqScan);
  c_fault_irq: cover property (irqFault);
endmodule : ltc_top
`default_nettype wire

//--- test/ltc_panel_model.sv
// Panel model: makes the pixel clock and measures sync and enable timing.
`timescale 1ns/1ns
`default_nettype none
module ltc_panel_model (
  // Control.
  input wire logic run,
  // Panel pins.
  output logic pixClk,
  input wire logic hsyncIn,
  input wire logic vsyncIn,
  input wire logic deIn,
  // Measurements, active-high sync and enable assumed.
  output int lineLen,
  output int hsLen,
  output int deMax,
  output int frameLen
);
  int pixCnt = 0;
  int hsCnt = 0;
  int deCnt = 0;
  int lineCnt = 0;
  int deFrame = 0;
  logic hsPrev = 1'b0;
  logic vsPrev = 1'b0;
  initial begin
    pixClk = 1'b0;
    lineLen = 0;
    hsLen = 0;
    deMax = 0;
    frameLen = 0;
    forever begin
      if (run) begin
        #62;
        pixClk = 1'b1;
        #63;
        pixClk = 1'b0;
      end else begin
        #8;
      end
    end
  end
  // Sampling half a period late gives the synchroniser time to settle.
  always @(negedge pixClk) begin
    hsPrev <= hsyncIn;
    vsPrev <= vsyncIn;
    if (hsyncIn && !hsPrev) begin
      lineLen <= pixCnt;
      hsLen <= hsCnt;
      if (deCnt > deFrame) begin
        deFrame <= deCnt;
      end
      pixCnt <= 1;
      hsCnt <= 1;
      deCnt <= int'(deIn);
      lineCnt <= lineCnt + 1;
    end else begin
      pixCnt <= pixCnt + 1;
      hsCnt <= hsCnt + int'(hsyncIn);
      deCnt <= deCnt + int'(deIn);
    end
    if (vsyncIn && !vsPrev) begin
      // The enable width is latched per frame, so the long count from
      // before the polarity was set never reaches the reported value.
      frameLen <= lineCnt;
      lineCnt <= 1;
      deMax <= deFrame;
      deFrame <= 0;
    end
  end
endmodule : ltc_panel_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench of the display timing and event block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ltc_pkg::*;
  localparam int FRAME_CYC = 5 * 10 * 125 / 8 + 1;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, run;
  logic [LTC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic underrunEvent, busErrorEvent, pixClkIn, hsyncOut, vsyncOut;
  logic dataEnableOut, irqScan, irqFault, ditherEnable;
  logic [LTC_NUM_LAYERS*32-1:0] layerActive;
  int lineLen, hsLen, deMax, frameLen;
  int failCount = 0;
  int testsRun = 0;
  int cycles = 0;

  ltc_top #(.NUM_LAYERS(LTC_NUM_LAYERS)) i_ltc_top (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .underrunEvent(underrunEvent),
    .busErrorEvent(busErrorEvent), .pixClkIn(pixClkIn),
    .hsyncOut(hsyncOut), .vsyncOut(vsyncOut),
    .dataEnableOut(dataEnableOut), .irqScan(irqScan),
    .irqFault(irqFault), .ditherEnable(ditherEnable),
    .layerActive(layerActive));
  ltc_panel_model i_ltc_panel_model (
    .run(run), .pixClk(pixClkIn), .hsyncIn(hsyncOut), .vsyncIn(vsyncOut),
    .deIn(dataEnableOut), .lineLen(lineLen), .hsLen(hsLen),
    .deMax(deMax), .frameLen(frameLen));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic finishTest;
    $display("Comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finishTest

  // A hung handshake must not stall the run forever.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      finishTest;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string n, input logic [11:0] a,
    input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, LTC_RST_ZERO, q, e);
    chk(n, x, q);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic waitScan;
    int n;
    n = 0;
    while (irqScan !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    chk("scan irq raised", 32'h0000_0001, {31'h0, irqScan});
  endtask : waitScan

  task automatic testRegs;
    logic [11:0] ofs [4];
    logic [31:0] q;
    logic e;
    ofs = '{LTC_OFS_SYNC, LTC_OFS_PORCH, LTC_OFS_ACTIVE, LTC_OFS_TOTAL};
    chk("hsync idle", 32'h0000_0001, {31'h0, hsyncOut});
    foreach (ofs[i]) rd("timing reset", ofs[i], LTC_RST_ZERO);
    rd("global reset", LTC_OFS_GLOBAL, LTC_RST_GLOBAL);
    foreach (ofs[i]) wr(ofs[i], 32'h0ABC_0555);
    foreach (ofs[i]) rd("timing rw", ofs[i], 32'h0ABC_0555);
    apb(1'b0, 12'h0F0, LTC_RST_ZERO, q, e);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", LTC_RST_ZERO, q);
    $display("registers test done");
  endtask : testRegs

  task automatic testEvents;
    for (int b = 1; b <= 2; b++) begin
      @(posedge core_clk);
      underrunEvent <= (b == 1);
      busErrorEvent <= (b == 2);
      @(posedge core_clk);
      underrunEvent <= 1'b0;
      busErrorEvent <= 1'b0;
      rd("flag set", LTC_OFS_IRQ_STAT, 32'h1 << b);
      chk("masked irq", LTC_RST_ZERO, {31'h0, irqFault});
      wr(LTC_OFS_IRQ_EN, 32'h1 << b);
      settle(2);
      chk("enabled irq", 32'h0000_0001, {31'h0, irqFault});
      chk("scan quiet", LTC_RST_ZERO, {31'h0, irqScan});
      wr(LTC_OFS_IRQ_CLR, 32'h1 << b);
      rd("flag clear", LTC_OFS_IRQ_STAT, LTC_RST_ZERO);
      wr(LTC_OFS_IRQ_EN, LTC_RST_ZERO);
    end
    $display("events test done");
  endtask : testEvents

  task automatic testTiming;
    wr(LTC_OFS_SYNC, 32'h0001_0000);
    wr(LTC_OFS_PORCH, 32'h0003_0001);
    wr(LTC_OFS_ACTIVE, 32'h0007_0003);
    wr(LTC_OFS_TOTAL, 32'h0009_0004);
    wr(LTC_OFS_GLOBAL, 32'hE000_0000);
    settle(2);
    chk("hsync idle high", LTC_RST_ZERO, {31'h0, hsyncOut});
    chk("de idle high", LTC_RST_ZERO, {31'h0, dataEnableOut});
    wr(LTC_OFS_LINE_POS, 32'h0000_0002);
    wr(LTC_OFS_IRQ_EN, 32'h0000_0001);
    wr(LTC_OFS_RELOAD, 32'h0000_0001);
    wr(LTC_OFS_GLOBAL, 32'hE000_0001);
    waitScan;
    rd("line flag", LTC_OFS_IRQ_STAT, 32'h0000_0001);
    settle(2 * FRAME_CYC);
    chk("line length", 32'h0000_000A, lineLen);
    chk("hsync length", 32'h0000_0002, hsLen);
    chk("de length", 32'h0000_0004, deMax);
    chk("frame length", 32'h0000_0005, frameLen);
    wr(LTC_OFS_GLOBAL, 32'hE001_0001);
    settle(1);
    chk("dither on", 32'h0000_0001, {31'h0, ditherEnable});
    wr(LTC_OFS_IRQ_EN, LTC_RST_ZERO);
    wr(LTC_OFS_IRQ_CLR, 32'h0000_0001);
    $display("timing test done");
  endtask : testTiming

  task automatic testReload;
    logic [31:0] q;
    logic e;
    wr(LTC_OFS_LAYER_BASE, 32'h1234_5678);
    wr(LTC_OFS_LAYER_BASE, 32'hCAFE_0001);
    rd("shadow read", LTC_OFS_LAYER_BASE, LTC_RST_ZERO);
    chk("active held", LTC_RST_ZERO, layerActive[31:0]);
    wr(LTC_OFS_RELOAD, 32'h0000_0001);
    settle(2);
    chk("active now", 32'hCAFE_0001, layerActive[31:0]);
    rd("imm cleared", LTC_OFS_RELOAD, LTC_RST_ZERO);
    rd("active read", LTC_OFS_LAYER_BASE, 32'hCAFE_0001);
    wr(LTC_OFS_LAYER_BASE + LTC_OFS_LAYER_STRIDE, 32'h0BAD_F00D);
    wr(LTC_OFS_IRQ_EN, 32'h0000_0008);
    wr(LTC_OFS_RELOAD, 32'h0000_0002);
    wr(LTC_OFS_RELOAD, LTC_RST_ZERO);
    rd("blank pending", LTC_OFS_RELOAD, 32'h0000_0002);
    waitScan;
    apb(1'b0, LTC_OFS_IRQ_STAT, LTC_RST_ZERO, q, e);
    chk("reload flag", 32'h0000_0008, q & 32'h0000_0008);
    chk("active blank", 32'h0BAD_F00D, layerActive[63:32]);
    rd("blank cleared", LTC_OFS_RELOAD, LTC_RST_ZERO);
    $display("reload test done");
  endtask : testReload

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    underrunEvent = 1'b0;
    busErrorEvent = 1'b0;
    run = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    run <= 1'b1;
    settle(2);
    testRegs;
    testEvents;
    testTiming;
    testReload;
    finishTest;
  end
endmodule : tb_top
`default_nettype wire
